// ==== hdl/ram_fifo_pkg.sv ====
// constants, types and helpers for the embedded ram/fifo block
// assumes a single sys_clk domain and a 32-bit ahb-lite register port
package ram_fifo_pkg;
    localparam int CAPACITY_BITS = 4608;
    localparam int ADDR_W        = 12;
    localparam int DATA_W        = 18;
    localparam int CNT_W         = 13;
    // port width codes: 4k x1, 2k x2, 1k x4, 512 x9, 256 x18
    localparam logic [2:0] W1  = 3'h0;
    localparam logic [2:0] W2  = 3'h1;
    localparam logic [2:0] W4  = 3'h2;
    localparam logic [2:0] W9  = 3'h3;
    localparam logic [2:0] W18 = 3'h4;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DEPTH  = 8'h04;
    localparam logic [7:0] OFF_AF_THR = 8'h08;
    localparam logic [7:0] OFF_AE_THR = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_ST = 8'h14;
    localparam logic [7:0] OFF_INT_MK = 8'h18;
    // control fields
    localparam int CTRL_MODE  = 0;
    localparam int CTRL_WRW   = 1;
    localparam int CTRL_RDW   = 4;
    localparam int CTRL_CLEAR = 7;
    localparam int STAT_COUNT = 16;
    localparam int EV_W       = 6;
    // reset values
    localparam logic [6:0]       RST_CTRL  = 7'h00;
    localparam logic [CNT_W-1:0] RST_DEPTH = 13'h1000;
    localparam logic [CNT_W-1:0] RST_AF    = 13'h0F00;
    localparam logic [CNT_W-1:0] RST_AE    = 13'h0010;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_req_t;

    typedef struct packed {
        logic full;
        logic empty;
        logic near_full;
        logic near_empty;
    } fifo_flags_t;

    function automatic logic [4:0] width_of(input logic [2:0] c);
        unique case (c)
            W2:      width_of = 5'h02;
            W4:      width_of = 5'h04;
            W9:      width_of = 5'h09;
            W18:     width_of = 5'h12;
            default: width_of = 5'h01;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] depth_of(input logic [2:0] c);
        unique case (c)
            W2:      depth_of = 13'h0800;
            W4:      depth_of = 13'h0400;
            W9:      depth_of = 13'h0200;
            W18:     depth_of = 13'h0100;
            default: depth_of = 13'h1000;
        endcase
    endfunction
endpackage

// ==== hdl/ram_array.sv ====
// 4608-bit storage with independently sized write and read ports
// assumes addresses from one sys_clk domain; read data registered
`timescale 1ns/1ps
`default_nettype none
module ram_array (
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    input  wire ram_fifo_pkg::wr_req_t    wr,
    input  wire logic [2:0]               wr_width,
    input  wire logic                     rd_en,
    input  wire logic [11:0]              rd_addr,
    input  wire logic [2:0]               rd_width,
    output logic [17:0]                   rd_data
);
    logic        mem [0:ram_fifo_pkg::CAPACITY_BITS-1];
    logic [17:0] rd_data_next;
    wire  [4:0]  wr_w = ram_fifo_pkg::width_of(wr_width);
    wire  [4:0]  rd_w = ram_fifo_pkg::width_of(rd_width);
    // addresses wrap inside the selected depth so no access leaves the array
    wire  [11:0] wa   = wr.addr & 12'(ram_fifo_pkg::depth_of(wr_width) - 13'h1);
    wire  [11:0] ra   = rd_addr & 12'(ram_fifo_pkg::depth_of(rd_width) - 13'h1);
    wire  [16:0] wpos = wa * wr_w;
    wire  [16:0] rpos = ra * rd_w;

    // plain bit addressing keeps narrow ports aligned: nibble k is bits 4k..4k+3
    always_ff @(posedge sys_clk) begin
        for (int k = 0; k < 18; k++) begin
            if (wr.en && 5'(k) < wr_w) begin
                mem[13'(wpos) + 13'(k)] <= wr.data[k];
            end
        end
    end

    always_comb begin
        rd_data_next = 18'h00000;
        for (int k = 0; k < 18; k++) begin
            if (5'(k) < rd_w) begin
                rd_data_next[k] = mem[13'(rpos) + 13'(k)];
            end
        end
    end

    // a read of a cell written in the same cycle returns the old bits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_data <= 18'h00000;
        end else if (rd_en) begin
            rd_data <= rd_data_next;
        end
    end

    AST_NIBBLE_AS_BITS: assert property (@(posedge sys_clk) disable iff (reset)
        (wr.en && wr_width == ram_fifo_pkg::W4 && wr.addr[11:10] == 2'h0)
        ##1 (!wr.en && rd_en && rd_width == ram_fifo_pkg::W1
             && rd_addr == {$past(wr.addr[9:0]), 2'h1})
        |=> rd_data[0] == $past(wr.data[1], 2))
        else $error("nibble bit 1 not read back as single bit");
endmodule // ram_array
`default_nettype wire

// ==== hdl/fifo_ctrl.sv ====
// fifo pointer counters, fill level and flags
// assumes depth and thresholds held steady while the fifo holds data
`timescale 1ns/1ps
`default_nettype none
module fifo_ctrl (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic                       clear,
    input  wire logic [12:0]                depth,
    input  wire logic [12:0]                af_thr,
    input  wire logic [12:0]                ae_thr,
    input  wire logic                       push,
    input  wire logic                       pop,
    output logic [11:0]                     wr_ptr,
    output logic [11:0]                     rd_ptr,
    output logic [12:0]                     count,
    output ram_fifo_pkg::fifo_flags_t       flags,
    output logic                            push_ok,
    output logic                            pop_ok
);
    wire [11:0] last = 12'(depth - 13'h1);

    assign flags.full       = (count >= depth);
    assign flags.empty      = (count == 13'h0);
    assign flags.near_full  = (count >= af_thr);
    assign flags.near_empty = (count <= ae_thr);
    assign push_ok = push && !flags.full;
    assign pop_ok  = pop && !flags.empty;

    always_ff @(posedge sys_clk) begin
        if (reset || clear) begin
            wr_ptr <= 12'h000;
            rd_ptr <= 12'h000;
            count  <= 13'h0000;
        end else begin
            if (push_ok) begin
                wr_ptr <= (wr_ptr == last) ? 12'h000 : wr_ptr + 12'h001;
            end
            if (pop_ok) begin
                rd_ptr <= (rd_ptr == last) ? 12'h000 : rd_ptr + 12'h001;
            end
            count <= count + 13'(push_ok) - 13'(pop_ok);
        end
    end

    AST_PTR_ADVANCE: assert property (@(posedge sys_clk) disable iff (reset)
        (push_ok && !clear) |=> (wr_ptr == $past(wr_ptr) + 12'h001) || (wr_ptr == 12'h000))
        else $error("write pointer did not advance");
    AST_PTR_IN_DEPTH: assert property (@(posedge sys_clk) disable iff (reset)
        ($stable(depth) && $past(wr_ptr) < $past(depth)) |-> wr_ptr < depth)
        else $error("write pointer left configured depth");
    AST_FULL_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
        (flags.full && push && !pop && !clear) |=> $stable(wr_ptr) && $stable(count))
        else $error("write accepted while full");
    AST_EMPTY_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
        (flags.empty && pop && !push && !clear) |=> $stable(rd_ptr) && flags.empty)
        else $error("read accepted while empty");
    AST_LEAVE_EMPTY: assert property (@(posedge sys_clk) disable iff (reset)
        (flags.empty && push_ok && !clear) |=> !flags.empty && count == 13'h1)
        else $error("empty flag stuck after write");
    AST_NEAR_LEVELS: assert property (@(posedge sys_clk) disable iff (reset)
        (count == ae_thr |-> flags.near_empty) and (count == af_thr |-> flags.near_full))
        else $error("near flag missing at threshold");
endmodule // fifo_ctrl
`default_nettype wire

// ==== hdl/ram_fifo_block.sv ====
// embedded ram/fifo block: ahb-lite registers, ram and fifo modes
// assumes fabric ports and scan load port on sys_clk, no synchronisers
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - storage is 4608 bits in the x9 and x18 organisations, 4096 bits in x1, x2 and x4
// - organisations 256x18, 512x9, 1kx4, 2kx2, 4kx1 only
// - write and read ports work independently with separate widths in ram mode; in fifo mode the read side uses the write width
// - nibbles written on a 4-bit port read back as single bits
// - contents loadable through the scan access port for rom emulation
// - built-in fifo control, no extra fabric logic needed
// - fifo width and depth come from configuration
// - fifo gives full, empty and programmable near flags
// - internal counters produce read and write pointers
// - flags and fill level exported so blocks can be cascaded
module ram_fifo_block (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic          hready,
    input  wire logic [31:0]   hwdata,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          wr_en,
    input  wire logic [11:0]   wr_addr,
    input  wire logic [17:0]   wr_data,
    input  wire logic          rd_en,
    input  wire logic [11:0]   rd_addr,
    output logic [17:0]        rd_data,
    output logic               rd_valid,
    input  wire logic          scan_load_en,
    input  wire logic [11:0]   scan_addr,
    input  wire logic [17:0]   scan_data,
    output logic               full_flag,
    output logic               empty_flag,
    output logic               near_full_flag,
    output logic               near_empty_flag,
    output logic [12:0]        fill_count,
    output logic               irq
);
    // ************************************************************
    // registers and bus state
    // ************************************************************
    logic [6:0]              ctrl_reg;
    logic [12:0]             depth_reg;
    logic [12:0]             af_reg;
    logic [12:0]             ae_reg;
    logic [5:0]              int_st_reg;
    logic [5:0]              int_st_next;
    logic [5:0]              int_mk_reg;
    logic [3:0]              flags_prev_reg;
    logic                    wpend_reg;
    logic [7:0]              waddr_reg;
    logic                    rpend_reg;
    logic [7:0]              raddr_reg;
    logic [31:0]             hrdata_reg;
    logic                    rd_valid_reg;
    ram_fifo_pkg::wr_req_t   mem_wr;
    ram_fifo_pkg::fifo_flags_t flags;
    logic [11:0]             wr_ptr;
    logic [11:0]             rd_ptr;
    logic [12:0]             count;
    logic                    push_ok;
    logic                    pop_ok;

    // ************************************************************
    // ahb-lite decode
    // ************************************************************
    wire        take   = hsel && htrans[1] && hready;
    wire        wr_hit = wpend_reg;
    wire [31:0] wd     = hwdata;
    wire        w_ctrl = wr_hit && waddr_reg == ram_fifo_pkg::OFF_CTRL;
    wire        w_dep  = wr_hit && waddr_reg == ram_fifo_pkg::OFF_DEPTH;
    wire        w_af   = wr_hit && waddr_reg == ram_fifo_pkg::OFF_AF_THR;
    wire        w_ae   = wr_hit && waddr_reg == ram_fifo_pkg::OFF_AE_THR;
    wire        w_ist  = wr_hit && waddr_reg == ram_fifo_pkg::OFF_INT_ST;
    wire        w_imk  = wr_hit && waddr_reg == ram_fifo_pkg::OFF_INT_MK;

    // ************************************************************
    // configuration decode
    // ************************************************************
    wire        fifo_mode = ctrl_reg[ram_fifo_pkg::CTRL_MODE];
    wire [2:0]  wr_w      = ctrl_reg[ram_fifo_pkg::CTRL_WRW +: 3];
    wire [2:0]  rd_w      = ctrl_reg[ram_fifo_pkg::CTRL_RDW +: 3];
    wire [12:0] cap       = ram_fifo_pkg::depth_of(wr_w);
    // zero or oversized depth falls back to the full depth of the width
    wire [12:0] eff_depth = (depth_reg == 13'h0 || depth_reg > cap) ? cap
                            : depth_reg;
    wire        fifo_clr  = w_ctrl && wd[ram_fifo_pkg::CTRL_CLEAR];
    wire        push      = fifo_mode && wr_en && !scan_load_en;
    wire        pop       = fifo_mode && rd_en;

    // ************************************************************
    // port steering
    // ************************************************************
    // scan loading owns the write port; fabric writes in that cycle are dropped
    assign mem_wr.en   = scan_load_en || (fifo_mode ? push_ok : wr_en);
    assign mem_wr.addr = scan_load_en ? scan_addr
                       : (fifo_mode ? wr_ptr : wr_addr);
    assign mem_wr.data = scan_load_en ? scan_data : wr_data;
    wire        mem_rd_en   = fifo_mode ? pop_ok : rd_en;
    wire [11:0] mem_rd_addr = fifo_mode ? rd_ptr : rd_addr;
    // a fifo has one width, so the read side follows the write width
    wire [2:0]  mem_rd_w    = fifo_mode ? wr_w : rd_w;

    ram_array u_ram (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .wr       (mem_wr),
        .wr_width (wr_w),
        .rd_en    (mem_rd_en),
        .rd_addr  (mem_rd_addr),
        .rd_width (mem_rd_w),
        .rd_data  (rd_data)
    );

    fifo_ctrl u_fifo (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clear   (fifo_clr),
        .depth   (eff_depth),
        .af_thr  (af_reg),
        .ae_thr  (ae_reg),
        .push    (push),
        .pop     (pop),
        .wr_ptr  (wr_ptr),
        .rd_ptr  (rd_ptr),
        .count   (count),
        .flags   (flags),
        .push_ok (push_ok),
        .pop_ok  (pop_ok)
    );

    assign full_flag       = flags.full;
    assign empty_flag      = flags.empty;
    assign near_full_flag  = flags.near_full;
    assign near_empty_flag = flags.near_empty;
    assign fill_count      = count;
    assign rd_valid        = rd_valid_reg;

    // ************************************************************
    // interrupts
    // ************************************************************
    wire [3:0] fl_now = {flags.full, flags.empty, flags.near_full, flags.near_empty};
    wire       ovf    = push && flags.full && !fifo_clr;
    wire       udf    = pop && flags.empty && !fifo_clr;
    wire [5:0] ev     = {udf, ovf, fl_now & ~flags_prev_reg & {4{fifo_mode}}};
    wire [5:0] w1c    = w_ist ? wd[5:0] : 6'h00;
    // a new event in the clearing cycle survives the clear
    assign int_st_next = (int_st_reg & ~w1c) | ev;
    assign irq         = |(int_st_reg & int_mk_reg);

    // ************************************************************
    // read mux
    // ************************************************************
    wire [31:0] status_w = {3'h0, count, 12'h000, fl_now};
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        unique case (a)
            ram_fifo_pkg::OFF_CTRL:   rd_mux = {25'h0, ctrl_reg};
            ram_fifo_pkg::OFF_DEPTH:  rd_mux = {19'h0, depth_reg};
            ram_fifo_pkg::OFF_AF_THR: rd_mux = {19'h0, af_reg};
            ram_fifo_pkg::OFF_AE_THR: rd_mux = {19'h0, ae_reg};
            ram_fifo_pkg::OFF_STATUS: rd_mux = status_w;
            ram_fifo_pkg::OFF_INT_ST: rd_mux = {26'h0, int_st_reg};
            ram_fifo_pkg::OFF_INT_MK: rd_mux = {26'h0, int_mk_reg};
            default:                  rd_mux = 32'h00000000;
        endcase
    endfunction
    // one decoded word feeds the read register and its check alike
    wire [31:0] rd_word = rd_mux(raddr_reg);

    // one wait state on reads lets a write just before be seen
    assign hreadyout = !rpend_reg;
    assign hrdata    = hrdata_reg;
    assign hresp     = 1'b0;

    // ************************************************************
    // bus sequencing
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wpend_reg <= 1'b0;
            rpend_reg <= 1'b0;
            waddr_reg <= 8'h00;
            raddr_reg <= 8'h00;
        end else begin
            wpend_reg <= take && hwrite;
            rpend_reg <= take && !hwrite && !rpend_reg;
            if (take) begin
                waddr_reg <= {haddr[7:2], 2'h0};
                raddr_reg <= {haddr[7:2], 2'h0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hrdata_reg <= 32'h00000000;
        end else if (rpend_reg) begin
            hrdata_reg <= rd_word;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg  <= ram_fifo_pkg::RST_CTRL;
            depth_reg <= ram_fifo_pkg::RST_DEPTH;
            af_reg    <= ram_fifo_pkg::RST_AF;
            ae_reg    <= ram_fifo_pkg::RST_AE;
        end else begin
            if (w_ctrl) begin
                ctrl_reg <= wd[6:0];
            end
            if (w_dep) begin
                depth_reg <= wd[12:0];
            end
            if (w_af) begin
                af_reg <= wd[12:0];
            end
            if (w_ae) begin
                ae_reg <= wd[12:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_st_reg     <= 6'h00;
            int_mk_reg     <= 6'h00;
            flags_prev_reg <= 4'h0;
            rd_valid_reg   <= 1'b0;
        end else begin
            int_st_reg     <= int_st_next;
            flags_prev_reg <= fl_now;
            rd_valid_reg   <= mem_rd_en;
            if (w_imk) begin
                int_mk_reg <= wd[5:0];
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_CAPACITY: assert property (@(posedge sys_clk) disable iff (reset)
        18'(ram_fifo_pkg::width_of(wr_w)) * 18'(cap) <= 18'h01200
        && 18'(ram_fifo_pkg::width_of(wr_w)) * 18'(cap) >= 18'h01000)
        else $error("organisation exceeds block capacity");
    AST_DEPTH_CAP: assert property (@(posedge sys_clk) disable iff (reset)
        eff_depth <= cap && eff_depth != 13'h0)
        else $error("effective depth outside organisation");
    AST_SCAN_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
        scan_load_en |-> mem_wr.en && mem_wr.addr == scan_addr
                         && mem_wr.data == scan_data && !push_ok)
        else $error("scan load did not own write port");
    AST_FIFO_NO_CLR: assert property (@(posedge sys_clk) disable iff (reset)
        (fifo_mode && push_ok && !fifo_clr && !pop_ok) |=> fill_count == $past(fill_count) + 13'h1)
        else $error("fifo fill level did not rise on write");
    AST_RD_WAIT: assert property (@(posedge sys_clk) disable iff (reset)
        (take && !hwrite) |=> !hreadyout ##1 (hreadyout && hrdata == $past(rd_word)))
        else $error("read answer not after one wait state");
    AST_EVENT_WINS: assert property (@(posedge sys_clk) disable iff (reset)
        (ovf && w_ist && wd[4]) |=> int_st_reg[4])
        else $error("overflow event lost to clear");
    AST_IRQ_FOLLOW: assert property (@(posedge sys_clk) disable iff (reset)
        (ev[0] && int_mk_reg[0] && !w_imk) |=> irq)
        else $error("unmasked event did not raise irq");
    // register loads: control, depth and mask writes must land whole, read width code included
    AST_CTRL_WIDTH: assert property (@(posedge sys_clk) disable iff (reset)
        w_ctrl |=> ctrl_reg == $past(wd[6:0]))
        else $error("control word not stored whole");
    AST_DEPTH_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
        w_dep |=> depth_reg == $past(wd[12:0]))
        else $error("fifo depth not stored");
    AST_MASK_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
        w_imk |=> int_mk_reg == $past(wd[5:0]))
        else $error("interrupt mask not stored");
    AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (reset)
        (fifo_mode && pop_ok) |=> rd_valid)
        else $error("accepted pop gave no valid pulse");
    AST_EMPTY_NO_VALID: assert property (@(posedge sys_clk) disable iff (reset)
        (fifo_mode && rd_en && empty_flag) |=> !rd_valid)
        else $error("pop on empty fifo gave valid data");
    AST_CLEAR_EMPTIES: assert property (@(posedge sys_clk) disable iff (reset)
        fifo_clr |=> fill_count == 13'h0000 && empty_flag)
        else $error("fifo clear left entries behind");
    AST_OVF_SETS: assert property (@(posedge sys_clk) disable iff (reset)
        (fifo_mode && wr_en && !scan_load_en && full_flag && !fifo_clr) |=> int_st_reg[4])
        else $error("write on full fifo not flagged");
    AST_W1C_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
        (w_ist && wd[5] && !udf) |=> !int_st_reg[5])
        else $error("underflow bit not cleared by write of one");
endmodule // ram_fifo_block
`default_nettype wire

// ==== verif/fabric_user.sv ====
// fabric user logic model on the block's write and read ports
// assumes the bench calls put and get, one request per call
`timescale 1ns/1ps
`default_nettype none
module fabric_user (
    input  wire logic   sys_clk,
    input  wire logic   full_flag,
    output logic        wr_en,
    output logic [11:0] wr_addr,
    output logic [17:0] wr_data,
    output logic        rd_en,
    output logic [11:0] rd_addr
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_addr = 12'h000;
        wr_data = 18'h00000;
        rd_addr = 12'h000;
    end
    // polite user logic holds back when full unless told to misbehave
    task automatic put(input logic [11:0] a, input logic [17:0] d, input logic rude);
        @(posedge sys_clk);
        wr_en <= rude | ~full_flag;
        wr_addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        wr_data <= ~d; // released bus shows no stale word
    endtask
    task automatic get(input logic [11:0] a);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
    endtask
endmodule // fabric_user
`default_nettype wire

// ==== verif/ram_fifo_block_bench.sv ====
// self-checking bench for the ram/fifo block
// assumes one sys_clk domain; registers reached over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module ram_fifo_block_bench;
    logic sys_clk = 1'b0, reset = 1'b1, hwrite = 1'b0, scan_load_en = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [11:0] scan_addr = 12'h000, wr_addr, rd_addr;
    logic [17:0] scan_data = 18'h00000, wr_data, rd_data;
    logic hreadyout, hresp, wr_en, rd_en, rd_valid, irq;
    logic full_flag, empty_flag, near_full_flag, near_empty_flag;
    logic [12:0] fill_count;
    logic [7:0] ra [7];
    logic [31:0] rv [7];
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    ram_fifo_block uut (.sys_clk(sys_clk), .reset(reset), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .scan_load_en(scan_load_en),
        .scan_addr(scan_addr), .scan_data(scan_data), .full_flag(full_flag),
        .empty_flag(empty_flag), .near_full_flag(near_full_flag),
        .near_empty_flag(near_empty_flag), .fill_count(fill_count), .irq(irq));
    fabric_user fab (.sys_clk(sys_clk), .full_flag(full_flag), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic pop_chk(input logic vld, input logic [17:0] d);
        fab.get(12'h000);
        #1;
        `CHK(rd_valid, vld)
        if (vld) `CHK(rd_data, d)
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
        rv = '{32'h0, 32'h1000, 32'h0F00, 32'h10, 32'h5, 32'h0, 32'h0};
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            `CHK(q, rv[i])
        end
        $display("reset and map rows done");
        // a read width code above 3 needs bit 6 of the control word to stick
        ahb(1'b1, ram_fifo_pkg::OFF_CTRL, 32'h48);
        ahb(1'b0, ram_fifo_pkg::OFF_CTRL, 32'h0);
        `CHK(q, 32'h48)
        // ram mode: nibble write port, single-bit read port
        ahb(1'b1, ram_fifo_pkg::OFF_CTRL, {25'h0, ram_fifo_pkg::W1, ram_fifo_pkg::W4, 1'b0});
        // read one bit back in the cycle right after its nibble lands
        fork
            fab.put(12'h000, 18'h0000A, 1'b1);
            begin
                @(posedge sys_clk);
                fab.get(12'h001);
            end
        join
        #1;
        `CHK(rd_data[0], 1'b1)
        @(posedge sys_clk);
        scan_load_en <= 1'b1;
        scan_addr <= 12'h001;
        scan_data <= 18'h00005;
        @(posedge sys_clk);
        scan_load_en <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            fab.get(12'(k));
            @(posedge sys_clk);
            #1;
            `CHK(rd_data[0], 1'((8'h5A >> k) & 8'h01))
        end
        $display("mixed width ram test done");
        // fifo of 4 entries x9, near_full at 3, near_empty at 1
        ahb(1'b1, ram_fifo_pkg::OFF_CTRL, {24'h0, 1'b1, ram_fifo_pkg::W9, ram_fifo_pkg::W9, 1'b1});
        ahb(1'b1, ram_fifo_pkg::OFF_DEPTH, 32'h4);
        ahb(1'b1, ram_fifo_pkg::OFF_AF_THR, 32'h3);
        ahb(1'b1, ram_fifo_pkg::OFF_AE_THR, 32'h1);
        ahb(1'b1, ram_fifo_pkg::OFF_INT_MK, 32'h31);
        for (int i = 0; i < 5; i++) begin
            fab.put(12'h000, 18'(32'h100 + i), 1'b1);
            @(posedge sys_clk);
            #1;
            `CHK(fill_count, 13'(i < 4 ? i + 1 : 4))
            `CHK(near_full_flag, 1'(i >= 2))
            `CHK(near_empty_flag, 1'(i == 0))
            `CHK(full_flag, 1'(i >= 3))
        end
        `CHK(irq, 1'b1)
        // a refused write in the very cycle of the clear keeps its bit
        fork
            ahb(1'b1, ram_fifo_pkg::OFF_INT_ST, 32'h3F);
            begin
                @(posedge sys_clk);
                fab.put(12'h000, 18'h001FF, 1'b1);
            end
        join
        #1;
        `CHK(irq, 1'b1)
        `CHK(fill_count, 13'h0004)
        ahb(1'b1, ram_fifo_pkg::OFF_INT_ST, 32'h3F);
        #1;
        `CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++) pop_chk(1'b1, 18'(32'h100 + i));
        `CHK(empty_flag, 1'b1)
        pop_chk(1'b0, 18'h0);
        `CHK(fill_count, 13'h0000)
        ahb(1'b0, ram_fifo_pkg::OFF_INT_ST, 32'h0);
        `CHK(q[5], 1'b1)
        `CHK(q[0], 1'b1)
        `CHK(irq, 1'b1)
        $display("fifo fill, refuse and drain done");
        end_sim();
    end
endmodule // ram_fifo_block_bench
`default_nettype wire
